// ### inc/hpf_pkg.sv
`default_nettype none
package hpf_pkg;

    // DSP side word addresses on the internal data bus
    localparam logic [15:0] DSP_CTRL_ADDR = 16'hFFC4;
    localparam logic [15:0] DSP_STAT_ADDR = 16'hFFC5;
    localparam logic [15:0] DSP_DATA_ADDR = 16'hFFC6;

    // Host side byte offsets on the 8-bit port
    localparam logic [2:0] HOST_ICR_OFS = 3'h0;
    localparam logic [2:0] HOST_CVR_OFS = 3'h1;
    localparam logic [2:0] HOST_ISR_OFS = 3'h2;
    localparam logic [2:0] HOST_HIGH_OFS = 3'h6;
    localparam logic [2:0] HOST_LOW_OFS = 3'h7;

    // DSP control and status field positions
    localparam int CTRL_RX_IE = 0;
    localparam int CTRL_TX_IE = 1;
    localparam int CTRL_CMD_IE = 2;
    localparam int CTRL_D2H_F0 = 3;
    localparam int CTRL_D2H_F1 = 4;
    localparam int STAT_DMA = 7;

    // Host control field positions
    localparam int ICR_RX_REQ = 0;
    localparam int ICR_TX_REQ = 1;
    localparam int ICR_H2D_F0 = 3;
    localparam int ICR_MODE_LO = 5;
    localparam int ICR_MODE_HI = 6;
    localparam int ICR_INIT = 7;

    // Command vector register fields
    localparam int CVR_CMD_REQ = 7;
    localparam int CVR_VEC_W = 5;

    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        HPF_MODE_IRQ = 2'h0,
        HPF_MODE_ILLEGAL = 2'h1,
        HPF_MODE_DMA16 = 2'h2,
        HPF_MODE_DMA8 = 2'h3
    } hpf_mode_t;

    typedef struct packed {
        logic [2:0] addr;
        logic rd;
        logic wr;
        logic [7:0] data;
    } hpf_host_bus_t;

    typedef struct packed {
        logic [4:0] ctrl;
        logic rx_req_en;
        logic tx_req_en;
        hpf_mode_t mode;
        logic [1:0] h2d_flag;
        logic init;
        logic cmd_req;
        logic [CVR_VEC_W-1:0] cmd_vec;
        logic dsp_rx_full;
        logic dsp_tx_empty;
        logic host_rx_full;
        logic host_tx_empty;
        logic [WORD_W-1:0] dsp_rx_word;
        logic [WORD_W-1:0] dsp_tx_word;
        logic [WORD_W-1:0] host_tx_pair;
        logic [WORD_W-1:0] host_rx_pair;
        logic [WORD_W-1:0] dsp_rdata;
        logic [7:0] host_rdata;
        logic host_oe;
    } hpf_state_t;

    localparam hpf_state_t HPF_STATE_RESET = '{dsp_tx_empty: 1'b1, host_tx_empty: 1'b1, mode: HPF_MODE_IRQ,
                                              default: '0};

endpackage
`default_nettype wire

// ### core/hpf_host_port.sv
`timescale 1ns/10ps
`default_nettype none


module hpf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } hpf_fifo_state_t;

    hpf_fifo_state_t st;
    hpf_fifo_state_t next_st;
    logic push;
    logic pop;

    assign in_ready_o = (st.count != FULL);
    assign out_valid_o = (st.count != '0);
    assign out_data_o = st.mem[st.rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data_i;
            next_st.wr_ptr = (st.wr_ptr == LAST) ? '0 : st.wr_ptr + PW'(1);
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == LAST) ? '0 : st.rd_ptr + PW'(1);
        end
        if (push && !pop) begin
            next_st.count = st.count + CW'(1);
        end else if (pop && !push) begin
            next_st.count = st.count - CW'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

module hpf_host_port (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [15:0] dsp_addr_i,
    input wire logic dsp_rd_i,
    input wire logic dsp_wr_i,
    input wire logic [15:0] dsp_wdata_i,
    output logic [15:0] dsp_rdata_o,
    output logic dsp_rx_irq_o,
    output logic dsp_tx_irq_o,
    output logic dsp_cmd_irq_o,
    output logic [15:0] cmd_start_addr_o,
    input wire logic cmd_taken_i,
    input wire logic [2:0] host_addr_i,
    input wire logic host_rd_i,
    input wire logic host_wr_i,
    input wire logic [7:0] host_data_i,
    output logic [7:0] host_data_o,
    output logic host_data_oe_o,
    output logic host_request_pin_n_o,
    output logic dma_enable_o,
    output logic dma_byte_wide_o,
    output logic dma_dir_d2h_o
);
    hpf_pkg::hpf_state_t st;
    hpf_pkg::hpf_state_t next_st;
    hpf_pkg::hpf_host_bus_t hbus;
    logic [7:0] dsp_stat;
    logic [7:0] host_stat;
    logic [7:0] host_ctrl;
    logic host_request_pin_active;
    logic dma_on;
    logic d_ctrl_wr;
    logic d_data_wr;
    logic d_data_rd;
    logic h_icr_wr;
    logic h_cvr_wr;
    logic h_low_wr;
    logic h_high_wr;
    logic h_low_rd;
    logic f_in_valid;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [15:0] f_out_data;

    assign hbus = '{addr: host_addr_i, rd: host_rd_i, wr: host_wr_i, data: host_data_i};
    assign d_ctrl_wr = dsp_wr_i && (dsp_addr_i == hpf_pkg::DSP_CTRL_ADDR);
    assign d_data_wr = dsp_wr_i && (dsp_addr_i == hpf_pkg::DSP_DATA_ADDR);
    assign d_data_rd = dsp_rd_i && (dsp_addr_i == hpf_pkg::DSP_DATA_ADDR);
    // Host control is reached only from the host port
    assign h_icr_wr = hbus.wr && (hbus.addr == hpf_pkg::HOST_ICR_OFS);
    assign h_cvr_wr = hbus.wr && (hbus.addr == hpf_pkg::HOST_CVR_OFS);
    assign h_high_wr = hbus.wr && (hbus.addr == hpf_pkg::HOST_HIGH_OFS);
    assign h_low_wr = hbus.wr && (hbus.addr == hpf_pkg::HOST_LOW_OFS);
    assign h_low_rd = hbus.rd && (hbus.addr == hpf_pkg::HOST_LOW_OFS);

    assign dma_on = (st.mode != hpf_pkg::HPF_MODE_IRQ);
    assign dma_enable_o = dma_on;
    assign dma_byte_wide_o = (st.mode == hpf_pkg::HPF_MODE_DMA8);
    // Both enables set in DMA mode is the host's fault; the receive enable then selects DSP-to-host
    assign dma_dir_d2h_o = dma_on && st.rx_req_en;

    // Same request equation serves interrupt mode and DMA mode direction select
    assign host_request_pin_active = (st.rx_req_en && st.host_rx_full)
                      || (st.tx_req_en && st.host_tx_empty);
    assign host_request_pin_n_o = !host_request_pin_active;

    assign dsp_rx_irq_o = st.ctrl[hpf_pkg::CTRL_RX_IE] && st.dsp_rx_full;
    assign dsp_tx_irq_o = st.ctrl[hpf_pkg::CTRL_TX_IE] && st.dsp_tx_empty;
    assign dsp_cmd_irq_o = st.ctrl[hpf_pkg::CTRL_CMD_IE] && st.cmd_req;
    assign cmd_start_addr_o = {10'h000, st.cmd_vec, 1'b0};

    // Pending mirrors the host request, so one flop serves both views
    assign dsp_stat = {dma_on, 2'b00, st.h2d_flag, st.cmd_req,
                       st.dsp_tx_empty, st.dsp_rx_full};
    assign host_stat = {host_request_pin_active, dma_on, 1'b0, st.ctrl[hpf_pkg::CTRL_D2H_F1:hpf_pkg::CTRL_D2H_F0],
                        st.host_tx_empty && !st.dsp_rx_full, st.host_tx_empty, st.host_rx_full};
    assign host_ctrl = {st.init, st.mode, st.h2d_flag, 1'b0, st.tx_req_en, st.rx_req_en};

    // Host-to-DSP words queue here; a slow DSP stalls the host side
    assign f_in_valid = !st.host_tx_empty && !h_low_wr;
    assign f_out_ready = !st.dsp_rx_full;

    hpf_fifo #(
        .WIDTH(hpf_pkg::WORD_W),
        .DEPTH(hpf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .in_valid_i(f_in_valid),
        .in_ready_o(f_in_ready),
        .in_data_i(st.host_tx_pair),
        .out_valid_o(f_out_valid),
        .out_ready_i(f_out_ready),
        .out_data_o(f_out_data)
    );

    always_comb begin
        next_st = st;
        next_st.dsp_rdata = '0;
        next_st.host_rdata = '0;
        next_st.host_oe = hbus.rd;
        // Initialize runs one cycle after the host sets it, whatever the mode
        if (st.init) begin
            next_st.init = 1'b0;
            if (st.rx_req_en) begin
                next_st.host_rx_full = 1'b0;
                next_st.dsp_tx_empty = 1'b1;
            end
            if (st.tx_req_en) begin
                next_st.host_tx_empty = 1'b1;
                next_st.dsp_rx_full = 1'b0;
            end
        end
        // Host read clear comes before the move so a word arriving in that cycle is kept
        if (h_low_rd) begin
            next_st.host_rx_full = 1'b0;
        end
        // Either direction moves independently, so DMA one way leaves the other free
        if (!st.dsp_tx_empty && !st.host_rx_full && !d_data_wr) begin
            next_st.host_rx_pair = st.dsp_tx_word;
            next_st.host_rx_full = 1'b1;
            next_st.dsp_tx_empty = 1'b1;
        end
        if (f_in_valid && f_in_ready) begin
            next_st.host_tx_empty = 1'b1;
        end
        if (d_data_rd && st.dsp_rx_full) begin
            next_st.dsp_rx_full = 1'b0;
        end
        if (f_out_valid && f_out_ready) begin
            next_st.dsp_rx_word = f_out_data;
            next_st.dsp_rx_full = 1'b1;
        end
        if (d_ctrl_wr) begin
            next_st.ctrl = dsp_wdata_i[4:0];
        end
        if (d_data_wr) begin
            next_st.dsp_tx_word = dsp_wdata_i;
            next_st.dsp_tx_empty = 1'b0;
        end
        if (h_high_wr) begin
            next_st.host_tx_pair[15:8] = hbus.data;
        end
        if (h_low_wr) begin
            next_st.host_tx_pair[7:0] = hbus.data;
            next_st.host_tx_empty = 1'b0;
        end
        if (h_icr_wr) begin
            next_st.rx_req_en = hbus.data[hpf_pkg::ICR_RX_REQ];
            next_st.tx_req_en = hbus.data[hpf_pkg::ICR_TX_REQ];
            next_st.h2d_flag = hbus.data[hpf_pkg::ICR_H2D_F0+1:hpf_pkg::ICR_H2D_F0];
            next_st.mode = hpf_pkg::hpf_mode_t'(hbus.data[hpf_pkg::ICR_MODE_HI:hpf_pkg::ICR_MODE_LO]);
            next_st.init = hbus.data[hpf_pkg::ICR_INIT];
        end
        // Exception clear first so a fresh host request in the same cycle wins
        if (cmd_taken_i) begin
            next_st.cmd_req = 1'b0;
        end
        if (h_cvr_wr) begin
            next_st.cmd_req = hbus.data[hpf_pkg::CVR_CMD_REQ];
            next_st.cmd_vec = hbus.data[hpf_pkg::CVR_VEC_W-1:0];
        end
        if (dsp_rd_i) begin
            unique case (dsp_addr_i)
                hpf_pkg::DSP_CTRL_ADDR: next_st.dsp_rdata = {11'h000, st.ctrl};
                hpf_pkg::DSP_STAT_ADDR: next_st.dsp_rdata = {8'h00, dsp_stat};
                hpf_pkg::DSP_DATA_ADDR: next_st.dsp_rdata = st.dsp_rx_word;
                default: next_st.dsp_rdata = '0;
            endcase
        end
        if (hbus.rd) begin
            unique case (hbus.addr)
                hpf_pkg::HOST_ICR_OFS: next_st.host_rdata = host_ctrl;
                hpf_pkg::HOST_CVR_OFS: next_st.host_rdata = {st.cmd_req, 2'b00, st.cmd_vec};
                hpf_pkg::HOST_ISR_OFS: next_st.host_rdata = host_stat;
                hpf_pkg::HOST_HIGH_OFS: next_st.host_rdata = st.host_rx_pair[15:8];
                hpf_pkg::HOST_LOW_OFS: next_st.host_rdata = st.host_rx_pair[7:0];
                default: next_st.host_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st <= hpf_pkg::HPF_STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign dsp_rdata_o = st.dsp_rdata;
    assign host_data_o = st.host_rdata;
    assign host_data_oe_o = st.host_oe;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    chk_rx_irq_gate: assert property (d_ctrl_wr && !dsp_wdata_i[0] |=> !dsp_rx_irq_o)
        else $error("receive interrupt raised while disabled");
    chk_tx_irq_raise: assert property (d_ctrl_wr && dsp_wdata_i[1] && st.dsp_tx_empty && !d_data_wr
                                       |=> dsp_tx_irq_o)
        else $error("transmit interrupt missing");
    chk_cmd_irq_raise: assert property (h_cvr_wr && hbus.data[7] && st.ctrl[2] && !d_ctrl_wr
                                        |=> dsp_cmd_irq_o && cmd_start_addr_o == {10'h000, $past(hbus.data[4:0]), 1'b0})
        else $error("command interrupt or vector wrong");
    chk_flag_mirror: assert property (d_ctrl_wr |=> host_stat[4:3] == $past(dsp_wdata_i[4:3]))
        else $error("DSP flags not mirrored to host status");
    chk_stat_read: assert property (dsp_rd_i && dsp_addr_i == hpf_pkg::DSP_STAT_ADDR
                                    |=> dsp_rdata_o[15:8] == 8'h00 && dsp_rdata_o[6:5] == 2'b00)
        else $error("status read upper bits not zero");
    chk_rx_full_clr: assert property (d_data_rd && st.dsp_rx_full |=> !st.dsp_rx_full)
        else $error("receive-full not cleared by DSP read");
    chk_tx_empty_clr: assert property (d_data_wr && !st.host_rx_full ##1 !d_data_wr
                                       |-> !st.dsp_tx_empty ##1 st.dsp_tx_empty && st.host_rx_full)
        else $error("transmit-empty not tracking DSP write");
    chk_cmd_taken: assert property (cmd_taken_i && !h_cvr_wr |=> !dsp_stat[2])
        else $error("command pending not cleared when taken");
    chk_dma_status: assert property (h_icr_wr |=> dsp_stat[7] == ($past(hbus.data[6:5]) != 2'b00))
        else $error("DMA status wrong");
    chk_host_request_pin_idle: assert property (!st.rx_req_en && !st.tx_req_en |-> host_request_pin_n_o)
        else $error("request pin active with both enables clear");
    chk_init_clear: assert property (h_icr_wr && hbus.data[7] && hbus.data[0] && !d_data_wr
                                     |=> st.init ##1 !st.init && !st.host_rx_full)
        else $error("initialize did not clear receive channel");

    cov_host_to_dsp: cover property (h_low_wr ##[1:8] dsp_rx_irq_o);
    cov_dsp_to_host: cover property (d_data_wr ##[1:8] !host_request_pin_n_o);
    cov_fifo_full: cover property (f_in_valid && !f_in_ready);
    cov_cmd_taken: cover property (dsp_cmd_irq_o ##1 cmd_taken_i);
endmodule

`default_nettype wire

// ### testbench/hpf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hpf_host_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] host_data_i,
    input wire logic host_data_oe_i,
    output logic [2:0] host_addr_o,
    output logic host_rd_o,
    output logic host_wr_o,
    output logic [7:0] host_data_o
);
    initial begin
        host_addr_o = 3'h0;
        host_rd_o = 1'b0;
        host_wr_o = 1'b0;
        host_data_o = 8'h00;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 3'h0 && v[6:5] != 2'h0 && v[1:0] == 2'h3) begin
            v[1] = 1'b0;
        end
        @(posedge sys_clk_i);
        #1;
        host_addr_o = a;
        host_data_o = v;
        host_wr_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        host_wr_o = 1'b0;
        // Released bus must not keep looking valid
        host_data_o = ~v;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        host_addr_o = a;
        host_rd_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        host_rd_o = 1'b0;
        // Undriven bus returns garbage, so a missing enable shows up as a mismatch
        d = (host_data_oe_i === 1'b1) ? host_data_i : ~host_data_i;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic sys_clk_i, reset_i, dsp_rd_i, dsp_wr_i, cmd_taken_i, h_rd, h_wr, h_oe, req_n;
    logic rx_irq, tx_irq, cmd_irq, dma_en, dma_wide, dma_d2h;
    logic [15:0] dsp_addr_i, dsp_wdata_i, dsp_rdata, cmd_addr;
    logic [2:0] h_addr;
    logic [7:0] h_wdata, h_rdata;
    int n_mismatch, checks;

    hpf_host_port dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .dsp_addr_i(dsp_addr_i),
        .dsp_rd_i(dsp_rd_i), .dsp_wr_i(dsp_wr_i), .dsp_wdata_i(dsp_wdata_i), .dsp_rdata_o(dsp_rdata),
        .dsp_rx_irq_o(rx_irq), .dsp_tx_irq_o(tx_irq), .dsp_cmd_irq_o(cmd_irq), .cmd_start_addr_o(cmd_addr),
        .cmd_taken_i(cmd_taken_i), .host_addr_i(h_addr), .host_rd_i(h_rd), .host_wr_i(h_wr),
        .host_data_i(h_wdata), .host_data_o(h_rdata), .host_data_oe_o(h_oe), .host_request_pin_n_o(req_n),
        .dma_enable_o(dma_en), .dma_byte_wide_o(dma_wide), .dma_dir_d2h_o(dma_d2h));

    hpf_host_model host_u (.sys_clk_i(sys_clk_i), .host_data_i(h_rdata), .host_data_oe_i(h_oe),
        .host_addr_o(h_addr), .host_rd_o(h_rd), .host_wr_o(h_wr), .host_data_o(h_wdata));

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp16(nm, {8'h00, e}, {8'h00, g});
    endtask
    task automatic cmp1(input string nm, input logic e, input logic g);
        cmp16(nm, {15'h0000, e}, {15'h0000, g});
    endtask

    task automatic dwr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        #1;
        dsp_addr_i = a;
        dsp_wdata_i = d;
        dsp_wr_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        dsp_wr_i = 1'b0;
    endtask
    task automatic drd(input logic [15:0] a, output logic [15:0] d);
        @(posedge sys_clk_i);
        #1;
        dsp_addr_i = a;
        dsp_rd_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        dsp_rd_i = 1'b0;
        d = dsp_rdata;
    endtask
    task automatic dstat(output logic [15:0] d);
        drd(hpf_pkg::DSP_STAT_ADDR, d);
    endtask
    task automatic hisr(output logic [7:0] d);
        host_u.rd(hpf_pkg::HOST_ISR_OFS, d);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // Status polling is bounded so a stuck flag cannot hang the run
    task automatic poll(input logic host, input int b, input logic v);
        logic [15:0] s;
        s = '0;
        for (int i = 0; i < 20; i++) begin
            if (host) hisr(s[7:0]);
            else dstat(s);
            if (s[b] === v) break;
        end
        cmp1("poll", v, s[b]);
    endtask

    task automatic t_reset();
        logic [15:0] w;
        logic [7:0] b;
        reset_i = 1'b1;
        repeat (5) @(posedge sys_clk_i);
        #1;
        reset_i = 1'b0;
        dstat(w);
        cmp16("stat", 16'h0002, w);
        drd(hpf_pkg::DSP_CTRL_ADDR, w);
        cmp16("ctrl", 16'h0000, w);
        host_u.rd(hpf_pkg::HOST_ICR_OFS, b);
        cmp8("icr", 8'h00, b);
        cmp1("req_n", 1'b1, req_n);
    endtask

    task automatic t_modes();
        logic [15:0] w;
        logic [7:0] b;
        for (int m = 0; m < 4; m++) begin
            host_u.wr(hpf_pkg::HOST_ICR_OFS, {1'b0, m[1:0], m[1:0], 3'b100});
            host_u.rd(hpf_pkg::HOST_ICR_OFS, b);
            cmp8("icr", {1'b0, m[1:0], m[1:0], 3'b000}, b);
            dstat(w);
            cmp16("stat", {8'h00, m != 0, 2'b00, m[1:0], 3'b010}, w);
            cmp1("dma_en", m != 0, dma_en);
            cmp1("dma_wide", m == 3, dma_wide);
        end
        dwr(hpf_pkg::DSP_STAT_ADDR, 16'h00FF);
        dstat(w);
        cmp16("stat", 16'h009A, w);
        host_u.wr(hpf_pkg::HOST_ICR_OFS, 8'h00);
    endtask

    task automatic t_ctrl();
        logic [15:0] w;
        logic [7:0] b;
        dwr(hpf_pkg::DSP_CTRL_ADDR, 16'h001F);
        drd(hpf_pkg::DSP_CTRL_ADDR, w);
        cmp16("ctrl", 16'h001F, w);
        hisr(b);
        cmp8("d2h", 8'h18, b & 8'h18);
        cmp1("tx_irq", 1'b1, tx_irq);
        cmp1("rx_irq", 1'b0, rx_irq);
        cmp1("cmd_irq", 1'b0, cmd_irq);
        dwr(hpf_pkg::DSP_CTRL_ADDR, 16'h0008);
        hisr(b);
        cmp8("d2h", 8'h08, b & 8'h18);
        cmp1("tx_irq", 1'b0, tx_irq);
    endtask

    task automatic t_h2d();
        logic [15:0] w;
        logic [7:0] b;
        dwr(hpf_pkg::DSP_CTRL_ADDR, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            host_u.wr(hpf_pkg::HOST_HIGH_OFS, 8'hA0);
            host_u.wr(hpf_pkg::HOST_LOW_OFS, i[7:0]);
            if (i < 5) poll(1'b1, 1, 1'b1);
        end
        idle(8);
        hisr(b);
        cmp1("h_tx_empty", 1'b0, b[1]);
        cmp1("rx_irq", 1'b1, rx_irq);
        for (int i = 0; i < 6; i++) begin
            poll(1'b0, 0, 1'b1);
            drd(hpf_pkg::DSP_DATA_ADDR, w);
            cmp16("rx_word", {8'hA0, i[7:0]}, w);
        end
        idle(8);
        dstat(w);
        cmp1("rx_full", 1'b0, w[0]);
        cmp1("rx_irq", 1'b0, rx_irq);
    endtask

    task automatic t_d2h();
        logic [7:0] b, c;
        dwr(hpf_pkg::DSP_CTRL_ADDR, 16'h0002);
        host_u.wr(hpf_pkg::HOST_ICR_OFS, 8'h01);
        dwr(hpf_pkg::DSP_DATA_ADDR, 16'h1234);
        cmp1("tx_irq", 1'b0, tx_irq);
        poll(1'b1, 0, 1'b1);
        cmp1("tx_irq", 1'b1, tx_irq);
        cmp1("req_n", 1'b0, req_n);
        host_u.rd(hpf_pkg::HOST_HIGH_OFS, b);
        host_u.rd(hpf_pkg::HOST_LOW_OFS, c);
        cmp16("h_rx", 16'h1234, {b, c});
        hisr(b);
        cmp1("h_rx_full", 1'b0, b[0]);
        cmp1("req_n", 1'b1, req_n);
        host_u.wr(hpf_pkg::HOST_ICR_OFS, 8'h02);
        cmp1("req_n", 1'b0, req_n);
        host_u.wr(hpf_pkg::HOST_ICR_OFS, 8'h00);
        cmp1("req_n", 1'b1, req_n);
    endtask

    task automatic t_dma();
        logic [15:0] w;
        logic [7:0] b, c;
        host_u.wr(hpf_pkg::HOST_ICR_OFS, 8'h41);
        cmp1("dma_d2h", 1'b1, dma_d2h);
        cmp1("req_n", 1'b1, req_n);
        dwr(hpf_pkg::DSP_DATA_ADDR, 16'hBEEF);
        poll(1'b1, 0, 1'b1);
        cmp1("req_n", 1'b0, req_n);
        host_u.rd(hpf_pkg::HOST_HIGH_OFS, b);
        host_u.rd(hpf_pkg::HOST_LOW_OFS, c);
        cmp16("h_rx", 16'hBEEF, {b, c});
        host_u.wr(hpf_pkg::HOST_HIGH_OFS, 8'h5A);
        host_u.wr(hpf_pkg::HOST_LOW_OFS, 8'hC3);
        poll(1'b0, 0, 1'b1);
        drd(hpf_pkg::DSP_DATA_ADDR, w);
        cmp16("rx_word", 16'h5AC3, w);
        host_u.wr(hpf_pkg::HOST_ICR_OFS, 8'h42);
        cmp1("dma_d2h", 1'b0, dma_d2h);
        cmp1("req_n", 1'b0, req_n);
        host_u.wr(hpf_pkg::HOST_ICR_OFS, 8'h40);
        cmp1("req_n", 1'b1, req_n);
        host_u.wr(hpf_pkg::HOST_ICR_OFS, 8'h00);
    endtask

    task automatic t_cmd();
        logic [15:0] w;
        logic [7:0] b;
        dwr(hpf_pkg::DSP_CTRL_ADDR, 16'h0004);
        host_u.wr(hpf_pkg::HOST_CVR_OFS, 8'h93);
        dstat(w);
        cmp1("pending", 1'b1, w[2]);
        cmp1("cmd_irq", 1'b1, cmd_irq);
        cmp16("cmd_addr", 16'h0026, cmd_addr);
        @(posedge sys_clk_i);
        #1;
        cmd_taken_i = 1'b1;
        idle(1);
        cmd_taken_i = 1'b0;
        idle(1);
        cmp1("cmd_irq", 1'b0, cmd_irq);
        host_u.rd(hpf_pkg::HOST_CVR_OFS, b);
        cmp1("cmd_req", 1'b0, b[7]);
        host_u.wr(hpf_pkg::HOST_CVR_OFS, 8'h85);
        cmp1("cmd_irq", 1'b1, cmd_irq);
        host_u.wr(hpf_pkg::HOST_CVR_OFS, 8'h05);
        dstat(w);
        cmp1("pending", 1'b0, w[2]);
        dwr(hpf_pkg::DSP_CTRL_ADDR, 16'h0000);
    endtask

    task automatic t_init();
        logic [15:0] w;
        logic [7:0] b;
        dwr(hpf_pkg::DSP_DATA_ADDR, 16'h7777);
        poll(1'b1, 0, 1'b1);
        // Second word cannot move while the host pair is still full
        dwr(hpf_pkg::DSP_DATA_ADDR, 16'h8888);
        idle(4);
        dstat(w);
        cmp1("tx_empty", 1'b0, w[1]);
        host_u.wr(hpf_pkg::HOST_ICR_OFS, 8'h81);
        idle(3);
        hisr(b);
        cmp1("h_rx_full", 1'b0, b[0]);
        dstat(w);
        cmp1("tx_empty", 1'b1, w[1]);
        host_u.rd(hpf_pkg::HOST_ICR_OFS, b);
        cmp8("icr", 8'h01, b);
        host_u.wr(hpf_pkg::HOST_ICR_OFS, 8'h00);
    endtask

    initial begin
        n_mismatch = 0;
        checks = 0;
        reset_i = 1'b1;
        dsp_addr_i = 16'h0000;
        dsp_wdata_i = 16'h0000;
        dsp_rd_i = 1'b0;
        dsp_wr_i = 1'b0;
        cmd_taken_i = 1'b0;
        t_reset();
        t_modes();
        t_ctrl();
        t_h2d();
        t_d2h();
        t_dma();
        t_cmd();
        t_init();
        // Reset again with flags and enables set
        host_u.wr(hpf_pkg::HOST_ICR_OFS, 8'h1B);
        t_reset();
        stop_test();
    end

    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
endmodule
`default_nettype wire
